//--- common/cswm_pkg.sv
// Package for the selective-wake mode control block
package cswm_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_QUANTA = 8'h08;
  localparam logic [7:0] OFS_SAMPLE = 8'h0C;
  localparam logic [7:0] OFS_ID = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_PAYLOAD = 8'h18;
  localparam logic [7:0] OFS_CNT_HIGH = 8'h1C;
  localparam logic [7:0] OFS_CNT_LOW = 8'h20;
  localparam logic [7:0] OFS_TRIM = 8'h24;
  localparam logic [7:0] OFS_OPTION = 8'h28;
  localparam logic [7:0] OFS_FD_CTRL = 8'h2C;
  // ----------------------------------------
  // Mode codes and values
  // ----------------------------------------
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_WK = 3'h1;
  localparam logic [2:0] MODE_OFF_SWK = 3'h4;
  localparam logic [2:0] MODE_SWK = 3'h5;
  localparam logic [1:0] TRIM_OPEN = 2'h3;
  localparam logic [5:0] COUNT_OVERFLOW = 6'h20;
  localparam logic [5:0] COUNT_ONE = 6'h01;
  localparam logic [15:0] MEAS_ONE = 16'h0001;
  localparam logic [7:0] FILT_ONE = 8'h01;
  localparam logic [7:0] SAMPLE_RESET = 8'h33;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SBC_NORMAL = 2'b00,
    SBC_STOP = 2'b01,
    SBC_SLEEP = 2'b10,
    SBC_FAILSAFE = 2'b11
  } cswm_sbc_type;
  typedef enum logic {
    MEAS_IDLE = 1'b0,
    MEAS_COUNT = 1'b1
  } cswm_meas_type;
  typedef struct packed {
    logic [19:0] rsvd;
    logic [1:0] clock_select;
    logic config_valid;
    logic [1:0] trim_enable;
    logic error_counter_disable;
    logic fd_tolerance_enable;
    logic wake_receiver_select;
    logic oscillator_measure_enable;
    logic [2:0] can_mode;
  } cswm_ctrl_type;
  typedef struct packed {
    logic [21:0] rsvd;
    logic [5:0] frame_error_count;
    logic selective_wake_system_error;
    logic frame_flag;
    logic pattern_flag;
    logic bus_wake_flag;
  } cswm_status_type;
  typedef struct packed {
    logic [31:0] id;
    logic [31:0] payload;
    logic wake_pattern;
    logic edl_seen;
    logic frame_good;
    logic frame_bad;
    logic end_of_frame;
  } cswm_frame_type;
endpackage : cswm_pkg

//--- rtl/cswm_mode_control.sv
// Selective-wake mode control, wake flags, error counter and trim access
`timescale 1ns/1ps
// Functional notes
// - Restart from normal: off stays off; plain modes become wake mode 001.
// - Restart from normal with selective mode: mode 101, system error set.
// - Pattern wake in plain mode: mode 001, wake and pattern flags set.
// - Frame wake: wake and frame flags; pattern flag unless before silence.
// - Counter overflow in selective sleep: wake, error flag, count 100000.
// - Failed configuration: plain wake; pattern wake also sets error flag.
// - Other wake source leaves bus flags clear and mode unchanged.
// - Fail-safe entry forces wake mode without selective wake.
// - Bus wake restarts from sleep, interrupts in normal or stop.
// - Every bus wake sets wake flag; detail flags and count readable.
// - Quanta per bit scaled by clock select; sample point separate.
// - Selected receiver used; frames matched to id, mask, payload.
// - Pulse length counted in cycles, readable as high and low bytes.
// - Trim and option writes only with trim enable 11 and measure on.
// - FD tolerance: EDL frames stop decoding, no checks, never wake.
// - Decoder ready again at end-of-frame of an ignored FD frame.
// - FD tolerance applies a minimum dominant duration filter.
// - FD tolerance off: count up on FD or bad, down on good.
// - FD tolerance on, disable off: count down on good frames and FD frame ends, held at overflow.
// - FD tolerance and disable both on: counter held cleared.
// - Counter disable bit cleared when silence timeout expires.
// - System error zero only while selective wake valid, no overflow.
module cswm_mode_control #(
  parameter int SYNC_PINS = 3
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [1:0] i_sbc_mode,
  input wire logic i_restart_from_normal,
  input wire logic i_failsafe_entry,
  input wire logic i_silence_expired,
  input wire logic i_frame_valid,
  input wire cswm_pkg::cswm_frame_type i_frame,
  input wire logic i_rx_normal,
  input wire logic i_rx_wake,
  input wire logic i_transceiver_transmit_input,
  output logic [2:0] o_can_mode,
  output logic o_swk_enabled,
  output logic o_wake_irq,
  output logic o_restart_req,
  output logic o_rx_bit,
  output logic [9:0] o_bit_quanta,
  output logic [7:0] o_sample_point,
  output logic [7:0] o_trim,
  output logic [7:0] o_option
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  cswm_pkg::cswm_ctrl_type ctrl;
  cswm_pkg::cswm_ctrl_type wctrl;
  cswm_pkg::cswm_status_type status;
  cswm_pkg::cswm_status_type wstat;
  cswm_pkg::cswm_meas_type meas_state;
  logic [7:0] bit_quanta_config;
  logic [7:0] sample_point_config;
  logic [31:0] wake_identifier_config;
  logic [31:0] wake_identifier_mask_config;
  logic [31:0] wake_payload_config;
  logic [7:0] oscillator_trim_config;
  logic [7:0] oscillator_option_config;
  logic [7:0] fd_tolerance_control;
  logic [15:0] meas_count;
  logic [15:0] meas_result;
  logic [7:0] dom_count;
  logic [SYNC_PINS-1:0] pin_raw;
  logic [SYNC_PINS-1:0] pin_lvl;
  logic fd_ignore;
  logic silence_seen;
  logic bus_wake;
  logic wr_en;
  logic setup;
  logic swk_selected;
  logic swk_active;
  logic plain_wake;
  logic in_sleep;
  logic frame_match;
  logic frame_wake;
  logic frame_fd_end;
  logic frame_ok;
  logic frame_good;
  logic frame_bad;
  logic st_wr;
  logic ctrl_wr;
  logic overflow;
  logic trim_open;
  logic rx_sel;
  logic [31:0] next_prdata;

  assign pin_raw = {i_transceiver_transmit_input, i_rx_wake, i_rx_normal};
  assign wctrl = cswm_pkg::cswm_ctrl_type'(i_pwdata);
  assign wstat = cswm_pkg::cswm_status_type'(i_pwdata);
  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite;
  assign st_wr = wr_en && i_paddr == cswm_pkg::OFS_STATUS;
  assign ctrl_wr = wr_en && i_paddr == cswm_pkg::OFS_CTRL;
  assign in_sleep = i_sbc_mode == cswm_pkg::SBC_SLEEP;
  assign swk_selected = ctrl.can_mode > cswm_pkg::MODE_OFF_SWK;
  assign swk_active = swk_selected && ctrl.config_valid
    && !status.selective_wake_system_error;
  assign plain_wake = (ctrl.can_mode == cswm_pkg::MODE_WK)
    || (ctrl.can_mode == cswm_pkg::MODE_SWK && !swk_active);
  assign overflow = status.frame_error_count == cswm_pkg::COUNT_OVERFLOW;
  assign trim_open = ctrl.trim_enable == cswm_pkg::TRIM_OPEN
    && ctrl.oscillator_measure_enable;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  generate
    for (genvar g = 0; g < SYNC_PINS; g++)
    begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge i_clk_sys or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          s3 <= 1'b1;
          pin_lvl[g] <= 1'b1;
        end
        else
        begin
          s1 <= pin_raw[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
          begin
            pin_lvl[g] <= s3;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Frame qualification
  // ----------------------------------------
  // Id under mask and any payload bit in common
  assign frame_match = (((i_frame.id ^ wake_identifier_config)
    & ~wake_identifier_mask_config) == cswm_pkg::ZERO_WORD)
    && ((i_frame.payload & wake_payload_config) != cswm_pkg::ZERO_WORD);
  // Skip tolerated FD frames
  assign frame_fd_end = i_frame_valid && fd_ignore && i_frame.end_of_frame;
  assign frame_ok = i_frame_valid && !fd_ignore
    && !(ctrl.fd_tolerance_enable && i_frame.edl_seen);
  assign frame_good = frame_ok && i_frame.frame_good;
  assign frame_bad = frame_ok && i_frame.frame_bad;
  assign frame_wake = frame_good && !i_frame.edl_seen && frame_match;

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      fd_ignore <= 1'b0;
    end
    else if (frame_fd_end)
    begin
      fd_ignore <= 1'b0;
    end
    else if (i_frame_valid && ctrl.fd_tolerance_enable && i_frame.edl_seen
      && !i_frame.end_of_frame)
    begin
      fd_ignore <= 1'b1;
    end
  end

  // ----------------------------------------
  // Frame error counter
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      status.frame_error_count <= '0;
    end
    else if (ctrl.fd_tolerance_enable && ctrl.error_counter_disable)
    begin
      status.frame_error_count <= '0;
    end
    else if (overflow)
    begin
      status.frame_error_count <= cswm_pkg::COUNT_OVERFLOW;
    end
    else if (ctrl.fd_tolerance_enable)
    begin
      if ((frame_good || frame_fd_end) && status.frame_error_count != '0)
      begin
        status.frame_error_count <= status.frame_error_count
          - cswm_pkg::COUNT_ONE;
      end
    end
    else if (frame_bad || (i_frame_valid && i_frame.edl_seen))
    begin
      status.frame_error_count <= status.frame_error_count
        + cswm_pkg::COUNT_ONE;
    end
    else if (frame_good && status.frame_error_count != '0)
    begin
      status.frame_error_count <= status.frame_error_count
        - cswm_pkg::COUNT_ONE;
    end
  end

  // ----------------------------------------
  // Wake detection and flags
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      silence_seen <= 1'b0;
    end
    else if (i_silence_expired)
    begin
      silence_seen <= 1'b1;
    end
    else if (frame_good)
    begin
      silence_seen <= 1'b0;
    end
  end

  // Wake-capable modes only
  assign bus_wake = (swk_active && (frame_wake || overflow))
    || (plain_wake && i_frame_valid && i_frame.wake_pattern);

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      status.bus_wake_flag <= 1'b0;
      status.pattern_flag <= 1'b0;
      status.frame_flag <= 1'b0;
    end
    else
    begin
      if (bus_wake)
      begin
        status.bus_wake_flag <= 1'b1;
      end
      else if (st_wr && wstat.bus_wake_flag)
      begin
        status.bus_wake_flag <= 1'b0;
      end
      if (plain_wake && i_frame_valid && i_frame.wake_pattern)
      begin
        status.pattern_flag <= 1'b1;
      end
      else if (swk_active && frame_wake && silence_seen)
      begin
        status.pattern_flag <= 1'b1;
      end
      else if (st_wr && wstat.pattern_flag)
      begin
        status.pattern_flag <= 1'b0;
      end
      if (swk_active && frame_wake)
      begin
        status.frame_flag <= 1'b1;
      end
      else if (st_wr && wstat.frame_flag)
      begin
        status.frame_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      status.selective_wake_system_error <= 1'b0;
    end
    else if (i_restart_from_normal && swk_selected)
    begin
      status.selective_wake_system_error <= 1'b1;
    end
    else if (swk_active && overflow)
    begin
      status.selective_wake_system_error <= 1'b1;
    end
    else if (swk_selected && !ctrl.config_valid)
    begin
      status.selective_wake_system_error <= 1'b1;
    end
    else if (st_wr && wstat.selective_wake_system_error)
    begin
      status.selective_wake_system_error <= 1'b0;
    end
  end
  assign status.rsvd = '0;

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_wake_irq <= 1'b0;
      o_restart_req <= 1'b0;
    end
    else
    begin
      o_restart_req <= bus_wake && in_sleep;
      o_wake_irq <= bus_wake && (i_sbc_mode == cswm_pkg::SBC_NORMAL
        || i_sbc_mode == cswm_pkg::SBC_STOP);
    end
  end

  // ----------------------------------------
  // Control register and mode remapping
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ctrl <= '0;
    end
    else
    begin
      if (i_failsafe_entry)
      begin
        ctrl.can_mode <= cswm_pkg::MODE_WK;
        ctrl.config_valid <= 1'b0;
      end
      else if (i_restart_from_normal)
      begin
        if (swk_selected)
        begin
          ctrl.can_mode <= cswm_pkg::MODE_SWK;
        end
        else if (ctrl.can_mode != cswm_pkg::MODE_OFF
          && ctrl.can_mode != cswm_pkg::MODE_OFF_SWK)
        begin
          ctrl.can_mode <= cswm_pkg::MODE_WK;
        end
      end
      else if (ctrl_wr)
      begin
        ctrl.can_mode <= wctrl.can_mode;
        ctrl.config_valid <= wctrl.config_valid;
      end
      if (i_silence_expired)
      begin
        ctrl.error_counter_disable <= 1'b0;
      end
      else if (ctrl_wr)
      begin
        ctrl.error_counter_disable <= wctrl.error_counter_disable;
      end
      if (ctrl_wr)
      begin
        ctrl.clock_select <= wctrl.clock_select;
        ctrl.trim_enable <= wctrl.trim_enable;
        ctrl.fd_tolerance_enable <= wctrl.fd_tolerance_enable;
        ctrl.wake_receiver_select <= wctrl.wake_receiver_select;
        ctrl.oscillator_measure_enable <= wctrl.oscillator_measure_enable;
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      bit_quanta_config <= '0;
      sample_point_config <= cswm_pkg::SAMPLE_RESET;
      wake_identifier_config <= '0;
      wake_identifier_mask_config <= '0;
      wake_payload_config <= '0;
      fd_tolerance_control <= '0;
      oscillator_trim_config <= '0;
      oscillator_option_config <= '0;
    end
    else if (wr_en)
    begin
      case (i_paddr)
        cswm_pkg::OFS_QUANTA: bit_quanta_config <= i_pwdata[7:0];
        cswm_pkg::OFS_SAMPLE: sample_point_config <= i_pwdata[7:0];
        cswm_pkg::OFS_ID: wake_identifier_config <= i_pwdata;
        cswm_pkg::OFS_MASK: wake_identifier_mask_config <= i_pwdata;
        cswm_pkg::OFS_PAYLOAD: wake_payload_config <= i_pwdata;
        cswm_pkg::OFS_FD_CTRL: fd_tolerance_control <= i_pwdata[7:0];
        cswm_pkg::OFS_TRIM:
        begin
          if (trim_open)
          begin
            oscillator_trim_config <= i_pwdata[7:0];
          end
        end
        cswm_pkg::OFS_OPTION:
        begin
          if (trim_open)
          begin
            oscillator_option_config <= i_pwdata[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Oscillator measurement
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meas_state <= cswm_pkg::MEAS_IDLE;
      meas_count <= '0;
      meas_result <= '0;
    end
    else
    begin
      unique case (meas_state)
        cswm_pkg::MEAS_IDLE:
        begin
          if (ctrl.oscillator_measure_enable && !pin_lvl[2])
          begin
            meas_state <= cswm_pkg::MEAS_COUNT;
            meas_count <= cswm_pkg::MEAS_ONE;
          end
        end
        cswm_pkg::MEAS_COUNT:
        begin
          if (!ctrl.oscillator_measure_enable)
          begin
            meas_state <= cswm_pkg::MEAS_IDLE;
          end
          else if (pin_lvl[2])
          begin
            meas_state <= cswm_pkg::MEAS_IDLE;
            meas_result <= meas_count;
          end
          else if (meas_count != '1)
          begin
            meas_count <= meas_count + cswm_pkg::MEAS_ONE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Receiver select and dominant filter
  // ----------------------------------------
  assign rx_sel = ctrl.wake_receiver_select ? pin_lvl[1] : pin_lvl[0];

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      dom_count <= '0;
      o_rx_bit <= 1'b1;
    end
    else if (rx_sel)
    begin
      dom_count <= '0;
      o_rx_bit <= 1'b1;
    end
    else
    begin
      if (dom_count != '1)
      begin
        dom_count <= dom_count + cswm_pkg::FILT_ONE;
      end
      if (!ctrl.fd_tolerance_enable || dom_count >= fd_tolerance_control)
      begin
        o_rx_bit <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_can_mode <= '0;
      o_swk_enabled <= 1'b0;
      o_bit_quanta <= '0;
      o_sample_point <= cswm_pkg::SAMPLE_RESET;
      o_trim <= '0;
      o_option <= '0;
    end
    else
    begin
      o_can_mode <= ctrl.can_mode;
      o_swk_enabled <= swk_active;
      o_bit_quanta <= {2'b00, bit_quanta_config} << ctrl.clock_select;
      o_sample_point <= sample_point_config;
      o_trim <= oscillator_trim_config;
      o_option <= oscillator_option_config;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always_comb
  begin
    next_prdata = '0;
    case (i_paddr)
      cswm_pkg::OFS_CTRL: next_prdata = ctrl;
      cswm_pkg::OFS_STATUS: next_prdata = status;
      cswm_pkg::OFS_QUANTA: next_prdata[7:0] = bit_quanta_config;
      cswm_pkg::OFS_SAMPLE: next_prdata[7:0] = sample_point_config;
      cswm_pkg::OFS_ID: next_prdata = wake_identifier_config;
      cswm_pkg::OFS_MASK: next_prdata = wake_identifier_mask_config;
      cswm_pkg::OFS_PAYLOAD: next_prdata = wake_payload_config;
      cswm_pkg::OFS_CNT_HIGH: next_prdata[7:0] = meas_result[15:8];
      cswm_pkg::OFS_CNT_LOW: next_prdata[7:0] = meas_result[7:0];
      cswm_pkg::OFS_TRIM: next_prdata[7:0] = oscillator_trim_config;
      cswm_pkg::OFS_OPTION: next_prdata[7:0] = oscillator_option_config;
      cswm_pkg::OFS_FD_CTRL: next_prdata[7:0] = fd_tolerance_control;
      default: next_prdata = '0;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end
    else
    begin
      o_pready <= setup;
      o_prdata <= (setup && !i_pwrite) ? next_prdata : '0;
      o_pslverr <= setup && (i_paddr > cswm_pkg::OFS_FD_CTRL
        || i_paddr[1:0] != 2'b00);
    end
  end
endmodule : cswm_mode_control

//--- dv/cswm_mode_control_chk.sv
// Port checker for the mode control block
`timescale 1ns/1ps
module cswm_mode_control_chk (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [1:0] i_sbc_mode,
  input wire logic i_restart_from_normal,
  input wire logic i_failsafe_entry,
  input wire logic [2:0] o_can_mode,
  input wire logic o_wake_irq,
  input wire logic o_restart_req
);
  // ---
  // Properties
  // ---
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);
  property p_rdy;
    i_psel && !i_penable |=> o_pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdy_only;
    o_pready |-> $past(i_psel && !i_penable);
  endproperty
  a_rdy_only: assert property (p_rdy_only) else $error("ready without setup");
  property p_err;
    i_psel && !i_penable && i_paddr > 8'h2C |=> o_pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no error on bad address");
  property p_fs;
    i_failsafe_entry |-> ##2 o_can_mode == cswm_pkg::MODE_WK;
  endproperty
  a_fs: assert property (p_fs) else $error("fail-safe mode wrong");
  property p_plain;
    i_restart_from_normal && !o_can_mode[2] && o_can_mode[1:0] != 2'b00 |-> ##2 o_can_mode == 3'h1;
  endproperty
  a_plain: assert property (p_plain) else $error("plain remap wrong");
  property p_swk;
    i_restart_from_normal && o_can_mode[2] && o_can_mode[1:0] != 2'b00 |-> ##2 o_can_mode == 3'h5;
  endproperty
  a_swk: assert property (p_swk) else $error("swk remap wrong");
  property p_irq;
    o_wake_irq |-> !o_restart_req && $past(i_sbc_mode[1]) == 1'b0;
  endproperty
  a_irq: assert property (p_irq) else $error("irq outside normal or stop");
  property p_rst;
    o_restart_req |-> $past(i_sbc_mode) == 2'b10;
  endproperty
  a_rst: assert property (p_rst) else $error("restart outside sleep");
  c_rst: cover property (o_restart_req);
  c_irq: cover property (o_wake_irq);
  c_fs: cover property (i_failsafe_entry ##2 o_can_mode == 3'h1);
endmodule : cswm_mode_control_chk

//--- dv/cswm_bus_model.sv
// Far side model: decoded frames, receive pins and host transmit pin
`timescale 1ns/1ps
module cswm_bus_model (
  input wire logic i_clk_sys,
  output logic o_frame_valid,
  output cswm_pkg::cswm_frame_type o_frame,
  output logic o_rx_normal,
  output logic o_rx_wake,
  output logic o_tx
);
  initial
  begin
    o_frame_valid = 1'b0;
    o_frame = '0;
    o_rx_normal = 1'b1;
    o_rx_wake = 1'b1;
    o_tx = 1'b1;
  end
  // One frame event, contents inverted once released
  task automatic send(input logic [31:0] id, input logic [31:0] pl, input logic [4:0] fl);
    @(posedge i_clk_sys);
    o_frame_valid <= 1'b1;
    o_frame <= {id, pl, fl};
    @(posedge i_clk_sys);
    o_frame_valid <= 1'b0;
    o_frame <= ~{id, pl, fl};
  endtask : send
  // Low pulse of n cycles on the transmit pin
  task automatic pulse_tx(input int n);
    @(posedge i_clk_sys);
    o_tx <= 1'b0;
    repeat (n) @(posedge i_clk_sys);
    o_tx <= 1'b1;
  endtask : pulse_tx
endmodule : cswm_bus_model

//--- dv/can_selective_wake_mode_control_test.sv
// Testbench for the selective-wake mode control block
`timescale 1ns/1ps
module can_selective_wake_mode_control_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = '0;
  logic [1:0] sbc = 2'b00;
  logic rfn = 1'b0;
  logic fse = 1'b0;
  logic sil = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fv;
  cswm_pkg::cswm_frame_type fr;
  logic rxn;
  logic rxw;
  logic txd;
  logic irq;
  logic rstq;
  logic [31:0] rd;
  logic serr;
  int errors = 0;
  int cmp_count = 0;
  int n_irq = 0;
  int n_rst = 0;
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    n_irq <= n_irq + int'(irq);
    n_rst <= n_rst + int'(rstq);
  end
  cswm_bus_model u_bus (.i_clk_sys(clk), .o_frame_valid(fv), .o_frame(fr),
    .o_rx_normal(rxn), .o_rx_wake(rxw), .o_tx(txd));
  cswm_mode_control u_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_sbc_mode(sbc),
    .i_restart_from_normal(rfn), .i_failsafe_entry(fse), .i_silence_expired(sil),
    .i_frame_valid(fv), .i_frame(fr), .i_rx_normal(rxn), .i_rx_wake(rxw),
    .i_transceiver_transmit_input(txd), .o_can_mode(), .o_swk_enabled(),
    .o_wake_irq(irq), .o_restart_req(rstq), .o_rx_bit(), .o_bit_quanta(),
    .o_sample_point(), .o_trim(), .o_option());
  // ---
  // Shared tasks
  // ---
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 16);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      errors++;
      end_sim();
    end
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(rd & m, e);
  endtask : rdc
  task automatic pls(input int k);
    @(posedge clk);
    rfn <= (k == 0);
    fse <= (k == 1);
    sil <= (k == 2);
    @(posedge clk);
    {rfn, fse, sil} <= 3'b000;
  endtask : pls
  task automatic arm(input logic [31:0] c);
    sbc <= cswm_pkg::SBC_NORMAL;
    apb(1'b1, 8'h00, '0);
    apb(1'b1, 8'h00, c);
    apb(1'b1, 8'h04, 32'h0000_000F);
  endtask : arm
  task automatic wake(input logic [1:0] s, input logic [4:0] f, input logic [31:0] e);
    sbc <= s;
    u_bus.send(32'h0000_0123, 32'h0000_0001, f);
    rdc(8'h04, 32'h0000_03FF, e);
  endtask : wake
  // ---
  // Scenarios
  // ---
  task automatic t_reset();
    rdc(8'h04, '1, '0);
    rdc(8'h0C, '1, 32'h0000_0033);
    rdc(8'h30, '1, '0);
    chk(32'(serr), 32'h0000_0001);
    $display("reset and map done");
  endtask : t_reset
  task automatic t_restart();
    for (int m = 0; m < 8; m++)
    begin
      arm(32'h0000_0200 | 32'(m));
      pls(0);
      rdc(8'h00, 32'h0000_0007, (m == 0 || m == 4) ? 32'(m) : (m > 4 ? 32'h5 : 32'h1));
      rdc(8'h04, 32'h0000_0008, m > 4 ? 32'h0000_0008 : 32'h0000_0000);
    end
    $display("restart remap done");
  endtask : t_restart
  task automatic t_wakes();
    int r;
    int q;
    r = n_rst;
    q = n_irq;
    apb(1'b1, 8'h10, 32'h0000_0123);
    apb(1'b1, 8'h14, '0);
    apb(1'b1, 8'h18, 32'h0000_0001);
    arm(32'h0000_0201);
    wake(cswm_pkg::SBC_SLEEP, 5'h10, 32'h0000_0003);
    arm(32'h0000_0201);
    wake(cswm_pkg::SBC_STOP, 5'h10, 32'h0000_0003);
    arm(32'h0000_0205);
    wake(cswm_pkg::SBC_SLEEP, 5'h04, 32'h0000_0005);
    arm(32'h0000_0205);
    pls(2);
    wake(cswm_pkg::SBC_SLEEP, 5'h04, 32'h0000_0007);
    chk(32'(n_rst - r), 32'h0000_0003);
    chk(32'(n_irq - q), 32'h0000_0001);
    $display("wake flags done");
  endtask : t_wakes
  task automatic t_fd();
    int r;
    r = n_rst;
    arm(32'h0000_0225);
    wake(2'h2, 5'h0C, '0);
    chk(32'(n_rst - r), '0);
    u_bus.send(32'h0000_0123, 32'h0000_0001, 5'h01);
    wake(2'h2, 5'h04, 32'h0000_0005);
    $display("fd tolerance done");
  endtask : t_fd
  task automatic t_overflow();
    int r;
    r = n_rst;
    arm(32'h0000_0205);
    sbc <= 2'h2;
    repeat (31) u_bus.send(32'h0000_0123, 32'h0000_0001, 5'h02);
    rdc(8'h04, 32'h0000_03FF, 32'h0000_01F0);
    wake(2'h2, 5'h02, 32'h0000_0209);
    chk(32'(n_rst - r), 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0265);
    rdc(8'h04, 32'h0000_03F0, '0);
    u_bus.send(32'h0000_0123, 32'h0000_0001, 5'h02);
    rdc(8'h04, 32'h0000_03F0, '0);
    pls(2);
    rdc(8'h00, 32'h0000_0040, '0);
    $display("error counter done");
  endtask : t_overflow
  task automatic t_osc();
    arm(32'h0000_0008);
    u_bus.pulse_tx(20);
    repeat (6) @(posedge clk);
    rdc(8'h20, '1, 32'h0000_0014);
    rdc(8'h1C, '1, '0);
    apb(1'b1, 8'h24, 32'h0000_005A);
    rdc(8'h24, '1, '0);
    apb(1'b1, 8'h00, 32'h0000_0188);
    apb(1'b1, 8'h24, 32'h0000_005A);
    apb(1'b1, 8'h28, 32'h0000_003C);
    rdc(8'h24, '1, 32'h0000_005A);
    rdc(8'h28, '1, 32'h0000_003C);
    apb(1'b1, 8'h00, 32'h0000_0008);
    apb(1'b1, 8'h28, 32'h0000_0011);
    rdc(8'h28, '1, 32'h0000_003C);
    $display("oscillator trim done");
  endtask : t_osc
  task automatic t_failsafe();
    arm(32'h0000_0207);
    pls(1);
    rdc(8'h00, 32'h0000_0207, 32'h0000_0001);
    $display("fail-safe done");
  endtask : t_failsafe
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_restart();
    t_wakes();
    t_fd();
    t_overflow();
    t_osc();
    t_failsafe();
    end_sim();
  end
endmodule : can_selective_wake_mode_control_test
bind cswm_mode_control cswm_mode_control_chk u_chk (.*);
